/* include/fpm_cfg.svh */
// Constants for the programmer-mode flash sequencer
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH
`define FPM_CMD_READ      8'h00
`define FPM_CMD_PROG      8'h40
`define FPM_CMD_ERASE     8'h20
`define FPM_CMD_STAT      8'h71
`define FPM_PAD_BYTE      8'hff
`define FPM_BLOCK_BYTES   8'h80
`define FPM_CLK_MHZ       50
`define FPM_SETUP_MS      10
`define FPM_SETUP_CYC     (`FPM_SETUP_MS * 1000 * `FPM_CLK_MHZ)
`define FPM_RC_ABN        7
`define FPM_RC_CMD        6
`define FPM_RC_PRG        5
`define FPM_RC_ERS        4
`define FPM_RC_CNT        1
`define FPM_RC_ADR        0
`define FPM_RC_RESET      8'h00
`endif

/* include/fpm_pkg.sv */
// Types for the programmer-mode flash sequencer
package fpm_pkg;
  typedef enum logic [2:0] {
    FPM_SETUP, FPM_READ, FPM_ERASE2, FPM_PROGDATA, FPM_BUSY, FPM_POLL,
    FPM_STAT2, FPM_STATUS
  } fpm_state_t;
  typedef enum logic [1:0] {FPM_OUT_MEM, FPM_OUT_POLL, FPM_OUT_RC} fpm_out_t;
endpackage : fpm_pkg

/* rtl/fpm_page_buf.sv */
// One 128-byte program page buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module fpm_page_buf (
  input  wire logic       core_clk, // Clock
  input  wire logic       wrEn,     // Write strobe
  input  wire logic [6:0] wrAddr,   // Write index
  input  wire logic [7:0] wrData,   // Write byte
  input  wire logic [6:0] rdAddr,   // Read index
  output logic      [7:0] rdData    // Registered read byte
);
  logic [7:0] mem [0:127];
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : fpm_page_buf
`default_nettype wire

/* rtl/fpm_seq.sv */
// Programmer-mode command, polling and status logic of the flash
// Contract
// - Auto-erase always clears the whole array, never a part.
// - Line 7 shows whether program or erase is still running.
// - Line 6 shows normal versus failed finish.
// - Poll byte 00 busy, 80 abnormal, c0 normal; bits 5..0 zero.
// - Poll flags kept until next command write, shown on CE and OE.
// - Status read mode reports cause of abnormal end.
// - Return code held until a non-status-read command write.
// - Code bits: 7 abnormal, 6 cmd, 5 prog, 4 erase, 1 count, 0 addr.
// - Code starts zero; bits 2 and 3 read zero.
// - Commands ignored during the 10 ms setup period.
// - After setup the device enters memory read mode itself.
// - Codes 00 read, 40 plus 128 writes, 20 twice, 71 twice.
// - Program writes one 128-byte block; unused bytes padded ff. The code pads nothing: the host writes all 128 bytes.
`timescale 1ns/10ps
`default_nettype none
`include "fpm_cfg.svh"
module fpm_seq #(
  parameter int SETUP_CYC = `FPM_SETUP_CYC // Setup lockout in cycles
) (
  input  wire logic                core_clk,       // Clock
  input  wire logic                rst,            // Async reset, high
  input  wire logic                chipSelN,       // Chip select, low
  input  wire logic                outEnN,         // Output enable, low
  input  wire logic                wrStrobe,       // One-cycle write pulse
  input  wire logic                program_enable_pin, // Program enable
  input  wire logic [16:0]         addrIn,         // Address pins
  input  wire logic [7:0]          dataIn,         // Data pins in
  output logic      [7:0]          dataOut,        // Data pins out
  output logic                     dataOe,         // Data drive enable
  output logic                     arrayEraseReq,  // Whole-array erase
  output logic                     pageProgReq,    // Program page start
  output logic      [16:0]         pageAddr,       // Page base address
  output logic                     pageRdAck,      // Page byte fetched
  output logic      [7:0]          pageRdData,     // Page byte to array
  input  wire logic [6:0]          pageRdIdx,      // Array fetch index
  output logic      [16:0]         memAddr,        // Array read address
  input  wire logic [7:0]          memData,        // Array read data
  input  wire logic                opDone,         // Array op finished
  input  wire logic                opFail,         // Array op failed
  input  wire logic                opCountOver,    // Count exceeded
  output logic                     opBusy,         // Internal busy
  output logic                     cmdReady        // Setup period over
);
  import fpm_pkg::*;
  ////////////////////////////////////////////////////////////////////
  fpm_state_t  state;
  fpm_out_t    outSel;
  logic [31:0] setupCnt;
  logic [7:0]  byteCnt;
  logic        isErase;
  logic        pollDone;
  logic        pollOk;
  logic [7:0]  retCode;
  logic [7:0]  bufRd;
  // Chip must be selected and read enabled to drive the bus
  wire         rdActive = !chipSelN && !outEnN;
  wire         cmdWr    = wrStrobe && !chipSelN;
  wire         blockOk  = (addrIn[6:0] == 7'h00);
  wire         lastByte = (byteCnt == `FPM_BLOCK_BYTES - 8'h01);
  wire         isStat   = (dataIn == `FPM_CMD_STAT);
  wire         knownCmd = (dataIn == `FPM_CMD_READ) ||
                          (dataIn == `FPM_CMD_PROG) ||
                          (dataIn == `FPM_CMD_ERASE) || isStat;
  wire [7:0]   pollByte = {pollDone, pollOk, 6'h00};
  wire [7:0]   next_dataOut = (outSel == FPM_OUT_POLL) ? pollByte :
                              (outSel == FPM_OUT_RC)   ? retCode  :
                              memData;
  ////////////////////////////////////////////////////////////////////
  fpm_page_buf u_buf (
    .core_clk (core_clk),
    .wrEn     (state == FPM_PROGDATA && cmdWr),
    .wrAddr   (byteCnt[6:0]),
    .wrData   (dataIn),
    .rdAddr   (pageRdIdx),
    .rdData   (bufRd)
  );
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataOut    <= 8'h00;
      dataOe     <= 1'b0;
      memAddr    <= 17'h00000;
      pageRdData <= 8'h00;
      pageRdAck  <= 1'b0;
    end else begin
      // flags shown on CE and OE
      dataOut    <= next_dataOut;
      dataOe     <= rdActive;
      memAddr    <= addrIn;
      pageRdData <= bufRd;
      pageRdAck  <= opBusy && !isErase;
    end
  end
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state         <= FPM_SETUP;
      outSel        <= FPM_OUT_MEM;
      setupCnt      <= 32'h00000000;
      byteCnt       <= 8'h00;
      isErase       <= 1'b0;
      pollDone      <= 1'b0;
      pollOk        <= 1'b0;
      retCode       <= `FPM_RC_RESET;
      arrayEraseReq <= 1'b0;
      pageProgReq   <= 1'b0;
      pageAddr      <= 17'h00000;
      opBusy        <= 1'b0;
      cmdReady      <= 1'b0;
    end else begin
      arrayEraseReq <= 1'b0;
      pageProgReq   <= 1'b0;
      unique case (state)
        FPM_SETUP: begin
          if (setupCnt == SETUP_CYC - 1) begin
            state    <= FPM_READ;
            cmdReady <= 1'b1;
          end else begin
            setupCnt <= setupCnt + 32'h00000001;
          end
        end
        FPM_READ, FPM_POLL, FPM_STATUS: begin
          if (cmdWr) begin
            if (!isStat) begin
              retCode <= `FPM_RC_RESET;
            end
            outSel <= FPM_OUT_MEM;
            if (dataIn == `FPM_CMD_PROG && program_enable_pin) begin
              state   <= FPM_PROGDATA;
              byteCnt <= 8'h00;
            end else if (dataIn == `FPM_CMD_ERASE && program_enable_pin) begin
              state <= FPM_ERASE2;
            end else if (isStat) begin
              state <= FPM_STAT2;
            end else begin
              state <= FPM_READ;
              if (!knownCmd) begin
                retCode[`FPM_RC_CMD] <= 1'b1;
                retCode[`FPM_RC_ABN] <= 1'b1;
              end
            end
          end
        end
        FPM_ERASE2: begin
          if (cmdWr) begin
            if (dataIn == `FPM_CMD_ERASE) begin
              arrayEraseReq <= 1'b1;
              isErase       <= 1'b1;
              opBusy        <= 1'b1;
              pollDone      <= 1'b0;
              pollOk        <= 1'b0;
              outSel        <= FPM_OUT_POLL;
              state         <= FPM_BUSY;
            end else begin
              retCode[`FPM_RC_CMD] <= 1'b1;
              retCode[`FPM_RC_ABN] <= 1'b1;
              state                <= FPM_READ;
            end
          end
        end
        FPM_PROGDATA: begin
          if (cmdWr) begin
            byteCnt <= byteCnt + 8'h01;
            if (byteCnt == 8'h00) begin
              pageAddr <= addrIn;
              if (!blockOk) begin
                retCode[`FPM_RC_ADR] <= 1'b1;
              end
            end
            if (lastByte) begin
              pageProgReq <= 1'b1;
              isErase     <= 1'b0;
              opBusy      <= 1'b1;
              pollDone    <= 1'b0;
              pollOk      <= 1'b0;
              outSel      <= FPM_OUT_POLL;
              state       <= FPM_BUSY;
            end
          end
        end
        FPM_BUSY: begin
          if (opDone || opFail) begin
            opBusy <= 1'b0;
            pollDone <= 1'b1;
            pollOk <= opDone && !opFail && !retCode[`FPM_RC_ADR];
            if (opFail || retCode[`FPM_RC_ADR]) begin
              retCode[`FPM_RC_ABN] <= 1'b1;
              retCode[`FPM_RC_PRG] <= retCode[`FPM_RC_PRG] | !isErase;
              retCode[`FPM_RC_ERS] <= retCode[`FPM_RC_ERS] | isErase;
              retCode[`FPM_RC_CNT] <= retCode[`FPM_RC_CNT] | opCountOver;
            end
            state <= FPM_POLL;
          end
        end
        FPM_STAT2: begin
          if (cmdWr) begin
            if (isStat) begin
              outSel <= FPM_OUT_RC;
              state  <= FPM_STATUS;
            end else begin
              retCode[`FPM_RC_CMD] <= 1'b1;
              retCode[`FPM_RC_ABN] <= 1'b1;
              state                <= FPM_READ;
            end
          end
        end
      endcase
    end
  end
endmodule : fpm_seq
`default_nettype wire

/* tb/fpm_seq_properties.sv */
// Port-level properties of the programmer-mode flash sequencer
`timescale 1ns/10ps
`default_nettype none
module fpm_seq_chk (
  input wire logic       core_clk,      // Clock
  input wire logic       rst,           // Async reset
  input wire logic       chipSelN,      // Chip select, low
  input wire logic       outEnN,        // Output enable, low
  input wire logic [7:0] dataOut,       // Data out
  input wire logic       dataOe,        // Data drive
  input wire logic       arrayEraseReq, // Erase start
  input wire logic       pageProgReq,   // Program start
  input wire logic       pageRdAck,     // Page byte fetched
  input wire logic       opDone,        // Op finished
  input wire logic       opFail,        // Op failed
  input wire logic       opBusy,        // Busy
  input wire logic       cmdReady       // Setup over
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_ERASE_BUSY: assert property (arrayEraseReq |-> opBusy)
    else $error("erase start without busy");
  AST_LOCKOUT: assert property (!cmdReady |-> !opBusy && !arrayEraseReq)
    else $error("operation during setup");
  AST_READY_KEEP: assert property (cmdReady |=> cmdReady)
    else $error("ready dropped");
  AST_BUSY_HOLD: assert property (
    opBusy && !opDone && !opFail |=> opBusy)
    else $error("busy dropped early");
  AST_BUSY_END: assert property (
    opBusy && (opDone || opFail) |=> !opBusy)
    else $error("busy held after finish");
  AST_DRIVE: assert property (
    1'b1 |=> dataOe == (!$past(chipSelN) && !$past(outEnN)))
    else $error("drive enable wrong");
  AST_BUSY_POLL: assert property (
    $past(opBusy, 2) && opBusy && dataOe |-> dataOut == 8'h00)
    else $error("poll byte not zero while busy");
  AST_END_FLAG: assert property (
    $fell(opBusy) |-> ##2 (!dataOe || dataOut[7] && dataOut[5:0] == 6'h00))
    else $error("done flag missing");
  AST_PROG_FETCH: assert property (
    pageProgReq |=> pageRdAck)
    else $error("page fetch missing");
  AST_FETCH_BUSY: assert property (
    pageRdAck |-> $past(opBusy))
    else $error("page fetch outside busy");
  AST_ERASE_NOFETCH: assert property (
    arrayEraseReq |=> !pageRdAck)
    else $error("page fetch during erase");
endmodule : fpm_seq_chk
bind fpm_seq fpm_seq_chk chk (.core_clk(core_clk), .rst(rst),
  .chipSelN(chipSelN), .outEnN(outEnN), .dataOut(dataOut), .dataOe(dataOe),
  .arrayEraseReq(arrayEraseReq), .pageProgReq(pageProgReq),
  .pageRdAck(pageRdAck), .opDone(opDone), .opFail(opFail),
  .opBusy(opBusy), .cmdReady(cmdReady));
`default_nettype wire

/* tb/fpm_array_model.sv */
// Behavioural flash array engine beside the sequencer
`timescale 1ns/10ps
`default_nettype none
module fpm_array_model (
  input  wire logic        core_clk, // Clock
  input  wire logic        startReq, // Erase or program start
  input  wire logic        failNext, // Next op ends badly
  input  wire logic [16:0] memAddr,  // Read address
  output logic      [7:0]  memData,  // Read byte
  output logic             opDone,   // Good finish pulse
  output logic             opFail    // Bad finish pulse
);
  logic [3:0] left = 4'h0;
  // Fixed pattern so reads can be predicted
  assign memData = memAddr[7:0] ^ 8'h5a;
  always @(posedge core_clk) begin
    left   <= startReq ? 4'h9 : (left != 4'h0 ? left - 4'h1 : 4'h0);
    opDone <= left == 4'h1 && !failNext;
    opFail <= left == 4'h1 && failNext;
  end
endmodule : fpm_array_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the programmer-mode flash sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0, rst = 1'b1, chipSelN = 1'b1, outEnN = 1'b1;
  logic        wrStrobe = 1'b0, program_enable_pin = 1'b1, failNext = 1'b0;
  logic [16:0] addrIn = 17'h0, memAddr;
  logic [7:0]  dataIn = 8'h0, dataOut, memData;
  logic        dataOe, arrayEraseReq, pageProgReq, opDone, opFail;
  logic        opBusy, cmdReady;
  logic        countOver = 1'b0;
  logic [6:0]  pageRdIdx = 7'h00;
  logic [16:0] pageAddr, progBase;
  logic [7:0]  pageRdData;
  logic [7:0]  pageBuf [0:127];
  logic [31:0] seed = 32'h858afd46;
  int          failures = 0, compares = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  fpm_seq #(.SETUP_CYC(20)) dut (.core_clk(core_clk), .rst(rst),
    .chipSelN(chipSelN), .outEnN(outEnN), .wrStrobe(wrStrobe),
    .program_enable_pin(program_enable_pin), .addrIn(addrIn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .arrayEraseReq(arrayEraseReq), .pageProgReq(pageProgReq),
    .pageAddr(pageAddr), .pageRdAck(), .pageRdData(pageRdData),
    .pageRdIdx(pageRdIdx),
    .memAddr(memAddr), .memData(memData), .opDone(opDone),
    .opFail(opFail), .opCountOver(countOver), .opBusy(opBusy),
    .cmdReady(cmdReady));
  fpm_array_model arr (.core_clk(core_clk),
    .startReq(arrayEraseReq | pageProgReq), .failNext(failNext),
    .memAddr(memAddr), .memData(memData), .opDone(opDone), .opFail(opFail));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %0s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkA(input string n, input logic [16:0] e,
                      input logic [16:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %0s expected %h seen %h", n, e, g);
    end
  endtask : chkA
  task automatic wr(input logic [7:0] d, input logic [16:0] a);
    @(posedge core_clk);
    wrStrobe <= 1'b1;
    dataIn   <= d;
    addrIn   <= a;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
    // Released bus shows no stale value
    dataIn   <= ~d;
  endtask : wr
  task automatic rd(input string n, input logic [16:0] a, input logic [7:0] e);
    @(posedge core_clk);
    outEnN <= 1'b0;
    addrIn <= a;
    repeat (3) @(posedge core_clk);
    #1 chk(n, e, dataOut);
    @(posedge core_clk);
    outEnN <= 1'b1;
    $display("test %0s done", n);
  endtask : rd
  task automatic idle;
    @(posedge core_clk);
    outEnN <= 1'b0;
    for (int i = 0; i < 200 && opBusy !== 1'b0 || i < 2; i++)
      @(posedge core_clk);
  endtask : idle
  task automatic stat(input logic [7:0] e);
    wr(8'h71, 17'h0);
    wr(8'h71, 17'h0);
    repeat (1000) @(posedge core_clk);
    rd("return code", 17'h0, e);
  endtask : stat
  task automatic erase(input logic f);
    failNext <= f;
    wr(8'h20, 17'h0);
    wr(8'h20, 17'h0);
    idle();
  endtask : erase
  task automatic prog(input logic [16:0] a);
    failNext <= 1'b0;
    wr(8'h40, 17'h0);
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      pageBuf[i] = i < 100 ? seed[7:0] : 8'hff;
      wr(pageBuf[i], a + 17'(i));
    end
    idle();
  endtask : prog
  task automatic page(input logic [6:0] i);
    @(posedge core_clk);
    pageRdIdx <= i;
    repeat (3) @(posedge core_clk);
    #1 chk("page byte", pageBuf[i], pageRdData);
    $display("test page byte %0d done", i);
  endtask : page
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst      <= 1'b0;
    chipSelN <= 1'b0;
    wr(8'h20, 17'h0);
    wr(8'h20, 17'h0);
    repeat (4) @(posedge core_clk);
    #1 chk("busy in setup", 8'h00, {7'h0, opBusy});
    while (cmdReady !== 1'b1) @(posedge core_clk);
    seed = lfsr(seed);
    rd("array byte", seed[16:0], seed[7:0] ^ 8'h5a);
    erase(1'b0);
    rd("erase poll", 17'h0, 8'hc0);
    stat(8'h00);
    erase(1'b1);
    rd("fail poll", 17'h0, 8'h80);
    stat(8'h90);
    stat(8'h90);
    wr(8'h00, 17'h0);
    stat(8'h00);
    erase(1'b0);
    progBase = {seed[16:7], 7'h00};
    prog(progBase);
    rd("prog poll", 17'h0, 8'hc0);
    chkA("page address", progBase, pageAddr);
    page(7'h00);
    page(seed[6:0]);
    page(7'h7f);
    erase(1'b0);
    prog({seed[16:7], 7'h01});
    rd("address poll", 17'h0, 8'h80);
    stat(8'ha1);
    wr(8'h55, 17'h0);
    stat(8'hc0);
    program_enable_pin <= 1'b0;
    wr(8'h20, 17'h0);
    wr(8'h20, 17'h0);
    repeat (4) @(posedge core_clk);
    program_enable_pin <= 1'b1;
    countOver          <= 1'b1;
    #1 chk("erase unarmed", 8'h00, {7'h0, opBusy});
    @(posedge core_clk);
    erase(1'b1);
    stat(8'h92);
    stop_test();
  end
endmodule : tb
`default_nettype wire
